// >>> rtl/lsw_defines.svh
// constants for the light sensor window register block
`ifndef LSW_DEFINES_SVH
`define LSW_DEFINES_SVH

// two-wire target address, 7 bits
`define LSW_DEV_ADDR     7'h10

// command codes
`define LSW_CMD_CONF     8'h00
`define LSW_CMD_UPPER    8'h01
`define LSW_CMD_LOWER    8'h02
`define LSW_CMD_PSM      8'h03
`define LSW_CMD_AMBIENT  8'h04
`define LSW_CMD_WHITE    8'h05
`define LSW_CMD_STATUS   8'h06

// configuration fields
`define LSW_CONF_SD      0
`define LSW_CONF_INT     1
`define LSW_PERS_LO      4
`define LSW_PERS_HI      5
`define LSW_CONF_RST     16'h0001

// power-saving fields
`define LSW_PSM_ON       0
`define LSW_PSM_SEL_LO   1
`define LSW_PSM_SEL_HI   2
`define LSW_PSM_MASK     16'h0007

// status fields
`define LSW_ST_BELOW     15
`define LSW_ST_ABOVE     14
`define LSW_ST_RSVD      14'h0000

// bit engine
`define LSW_BITS_BYTE    4'h8
`define LSW_PERS_ONE     4'h1

`endif

// >>> rtl/lsw_pkg.sv
// types shared by the light sensor window register block
`default_nettype none

package lsw_pkg;

    typedef enum logic [2:0] {
        ST_IDLE  = 3'b000,
        ST_ADDR  = 3'b001,
        ST_CMD   = 3'b010,
        ST_WDATA = 3'b011,
        ST_ACK   = 3'b100,
        ST_RDATA = 3'b101,
        ST_RACK  = 3'b110,
        ST_WAIT  = 3'b111
    } lsw_state_t;

    typedef struct packed {
        lsw_state_t  st;
        lsw_state_t  after;
        logic [3:0]  bitcnt;
        logic [7:0]  shreg;
        logic [7:0]  cmd;
        logic [7:0]  lo;
        logic [1:0]  nbytes;
        logic [15:0] tx;
        logic        host_ack;
        logic        sda_oe;
        logic        sda_out;
        logic        scl_p;
        logic        sda_p;
        logic [15:0] conf;
        logic [15:0] upper;
        logic [15:0] lower;
        logic [2:0]  power_saving_control;
        logic [15:0] ambient;
        logic [15:0] white;
        logic        below;
        logic        above;
        logic [3:0]  above_cnt;
        logic [3:0]  below_cnt;
    } lsw_regs_t;

endpackage

`default_nettype wire

// >>> rtl/lsw_sync.sv
// two flip-flop synchroniser for pin inputs
`timescale 1ns/1ps
`default_nettype none

module lsw_sync #(
    parameter int                 WIDTH       = 1,
    parameter logic [WIDTH-1:0]   RESET_VALUE = '0
) (
    // clock and reset
    input  wire logic             clk_i,
    input  wire logic             reset_i,
    // data
    input  wire logic [WIDTH-1:0] d_i,
    output logic      [WIDTH-1:0] q_o
);

    typedef struct packed {
        logic [WIDTH-1:0] meta;
        logic [WIDTH-1:0] sync;
    } lsw_sync_t;

    lsw_sync_t r;
    lsw_sync_t n;

    always_comb begin
        n      = r;
        n.meta = d_i;
        n.sync = r.meta;
    end

    always_ff @(posedge clk_i or posedge reset_i) begin
        if (reset_i) begin
            r <= '{meta: RESET_VALUE, sync: RESET_VALUE};
        end else begin
            r <= n;
        end
    end

    assign q_o = r.sync;

endmodule

`default_nettype wire

// >>> rtl/lsw_top.sv
// light sensor window registers behind a two-wire target port
//
// How it works
// (R01) upper bound register, code 01h, read/write
// (R02) lower bound register, code 02h, read/write
// (R03) bound bits 15:8 high byte, 7:0 low
// (R04) window compare only with interrupt function on
// (R05) power-saving bits 2:1 pick mode 1..4
// (R06) power-saving bit 0 enables saving, read/write
// (R07) power-saving bits 15:3 reserved, read zero
// (R08) ambient result read-only at code 04h
// (R09) ambient result high byte 15:8, low 7:0
// (R10) white result read-only at code 05h
// (R11) status bit 15 flags below-window crossing
// (R12) status bit 14 flags above-window crossing
// (R13) flags read-only, status bits 13:0 zero
// (R14) answer only target address 10h, bit0 read
// (R15) configuration bit 1 gates threshold function
// (R16) configuration bits 5:4 set persistence 1/2/4/8
// (R17) shutdown keeps last result readable
// (R18) status read clears flags, new crossing sets
// (R19) words travel low byte first
`timescale 1ns/1ps
`default_nettype none
`include "lsw_defines.svh"

module lsw_top (
    // clock and reset
    input  wire logic        clk_i,
    input  wire logic        reset_i,
    // two-wire pins, open drain
    input  wire logic        scl_i,
    input  wire logic        sda_i,
    output logic             sda_o,
    output logic             sda_oe_o,
    // measurement results, same clock
    input  wire logic        meas_valid_i,
    input  wire logic [15:0] ambient_i,
    input  wire logic [15:0] white_i,
    // controls to the front end
    output logic      [15:0] conf_o,
    output logic             power_saving_on_o,
    output logic      [1:0]  power_saving_select_o,
    // window state
    output logic             below_window_flag_o,
    output logic             above_window_flag_o
);
    import lsw_pkg::*;

    ////////////////////////////////////////////////////////////////////////////
    // pin sampling

    logic [1:0] pins_s;
    logic       scl_s;
    logic       sda_s;

    lsw_sync #(
        .WIDTH       (2),
        .RESET_VALUE (2'h3)
    ) u_sync (
        .clk_i   (clk_i),
        .reset_i (reset_i),
        .d_i     ({scl_i, sda_i}),
        .q_o     (pins_s)
    );

    assign scl_s = pins_s[1];
    assign sda_s = pins_s[0];

    ////////////////////////////////////////////////////////////////////////////
    // state

    localparam lsw_regs_t RST = '{
        st:        ST_IDLE,
        after:     ST_IDLE,
        bitcnt:    4'h0,
        shreg:     8'h00,
        cmd:       8'h00,
        lo:        8'h00,
        nbytes:    2'h0,
        tx:        16'h0000,
        host_ack:  1'b0,
        sda_oe:    1'b0,
        sda_out:   1'b0,
        scl_p:     1'b1,
        sda_p:     1'b1,
        conf:      `LSW_CONF_RST,
        upper:     16'h0000,
        lower:     16'h0000,
        power_saving_control:       3'h0,
        ambient:   16'h0000,
        white:     16'h0000,
        below:     1'b0,
        above:     1'b0,
        above_cnt: 4'h0,
        below_cnt: 4'h0
    };

    lsw_regs_t   r;
    lsw_regs_t   n;

    logic        scl_rise;
    logic        scl_fall;
    logic        start_det;
    logic        stop_det;
    logic [15:0] wr_word;
    logic [15:0] rd_word;
    logic [3:0]  pers_target;
    logic        wr_commit;
    logic        rd_load;

    // start and stop only count while the clock line is high
    assign scl_rise    = scl_s & ~r.scl_p;
    assign scl_fall    = ~scl_s & r.scl_p;
    assign start_det   = scl_s & r.scl_p & r.sda_p & ~sda_s;
    assign stop_det    = scl_s & r.scl_p & ~r.sda_p & sda_s;
    // (R19) high byte arrives second
    assign wr_word     = {r.shreg, r.lo};
    // (R16) persistence 1, 2, 4 or 8
    assign pers_target = `LSW_PERS_ONE << r.conf[`LSW_PERS_HI:`LSW_PERS_LO];

    // read mux; unmapped codes read as zero
    always_comb begin
        rd_word = 16'h0000;
        unique case (r.cmd)
            `LSW_CMD_CONF:    rd_word = r.conf;
            `LSW_CMD_UPPER:   rd_word = r.upper;
            `LSW_CMD_LOWER:   rd_word = r.lower;
            // (R07) reserved bits read zero
            `LSW_CMD_PSM:     rd_word = {13'h0000, r.power_saving_control};
            // (R08) ambient result read-only
            `LSW_CMD_AMBIENT: rd_word = r.ambient;
            // (R10) white result read-only
            `LSW_CMD_WHITE:   rd_word = r.white;
            // (R13) flags on top, rest zero
            `LSW_CMD_STATUS:  rd_word = {r.below, r.above, `LSW_ST_RSVD};
            default:          rd_word = 16'h0000;
        endcase
    end

    ////////////////////////////////////////////////////////////////////////////
    // next state

    always_comb begin
        n         = r;
        wr_commit = 1'b0;
        rd_load   = 1'b0;
        n.scl_p   = scl_s;
        n.sda_p   = sda_s;

        if (stop_det) begin
            n.st     = ST_IDLE;
            n.sda_oe = 1'b0;
        end else if (start_det) begin
            n.st     = ST_ADDR;
            n.bitcnt = 4'h0;
            n.sda_oe = 1'b0;
        end else begin
            unique case (r.st)
                ST_IDLE, ST_WAIT: begin
                    n.sda_oe = 1'b0;
                end
                ST_ADDR, ST_CMD, ST_WDATA: begin
                    if (scl_rise && r.bitcnt != `LSW_BITS_BYTE) begin
                        n.shreg  = {r.shreg[6:0], sda_s};
                        n.bitcnt = r.bitcnt + 4'h1;
                    end
                    if (scl_fall && r.bitcnt == `LSW_BITS_BYTE) begin
                        n.bitcnt = 4'h0;
                        n.sda_oe = 1'b1;
                        n.st     = ST_ACK;
                        if (r.st == ST_ADDR) begin
                            // (R14) other addresses get no acknowledge
                            if (r.shreg[7:1] != `LSW_DEV_ADDR) begin
                                n.sda_oe = 1'b0;
                                n.st     = ST_WAIT;
                            end else if (r.shreg[0]) begin
                                // (R19) low byte goes out first
                                rd_load  = 1'b1;
                                n.tx     = {rd_word[7:0], rd_word[15:8]};
                                n.after  = ST_RDATA;
                                n.nbytes = 2'h0;
                            end else begin
                                n.after  = ST_CMD;
                            end
                        end else if (r.st == ST_CMD) begin
                            n.cmd    = r.shreg;
                            n.nbytes = 2'h0;
                            n.after  = ST_WDATA;
                        end else if (r.nbytes == 2'h0) begin
                            n.lo     = r.shreg;
                            n.nbytes = 2'h1;
                            n.after  = ST_WDATA;
                        end else if (r.nbytes == 2'h1) begin
                            wr_commit = 1'b1;
                            n.nbytes  = 2'h2;
                            n.after   = ST_WDATA;
                        end else begin
                            // a third data byte is refused
                            n.sda_oe = 1'b0;
                            n.st     = ST_WAIT;
                        end
                    end
                end
                ST_ACK: begin
                    if (scl_fall) begin
                        n.sda_oe = 1'b0;
                        n.st     = r.after;
                        n.bitcnt = 4'h0;
                        if (r.after == ST_RDATA) begin
                            n.sda_oe = ~r.tx[15];
                            n.tx     = {r.tx[14:0], 1'b0};
                            n.bitcnt = 4'h1;
                        end
                    end
                end
                ST_RDATA: begin
                    if (scl_fall) begin
                        if (r.bitcnt == `LSW_BITS_BYTE) begin
                            n.sda_oe = 1'b0;
                            n.st     = ST_RACK;
                        end else begin
                            n.sda_oe = ~r.tx[15];
                            n.tx     = {r.tx[14:0], 1'b0};
                            n.bitcnt = r.bitcnt + 4'h1;
                        end
                    end
                end
                ST_RACK: begin
                    if (scl_rise) begin
                        n.host_ack = ~sda_s;
                    end
                    if (scl_fall) begin
                        // only two bytes per read; more would wrap nothing useful
                        if (r.host_ack && r.nbytes == 2'h0) begin
                            n.nbytes = 2'h1;
                            n.sda_oe = ~r.tx[15];
                            n.tx     = {r.tx[14:0], 1'b0};
                            n.bitcnt = 4'h1;
                            n.st     = ST_RDATA;
                        end else begin
                            n.st     = ST_WAIT;
                        end
                    end
                end
            endcase
        end

        // register writes; result and status codes ignore writes
        if (wr_commit) begin
            unique case (r.cmd)
                `LSW_CMD_CONF:  n.conf  = wr_word;
                // (R01) (R03) upper bound store
                `LSW_CMD_UPPER: n.upper = wr_word;
                // (R02) (R03) lower bound store
                `LSW_CMD_LOWER: n.lower = wr_word;
                // (R05) (R06) mode and enable only
                `LSW_CMD_PSM:   n.power_saving_control   = wr_word[`LSW_PSM_SEL_HI:`LSW_PSM_ON];
                default:        n.power_saving_control   = r.power_saving_control;
            endcase
        end

        // (R18) read clears flags, set below wins
        if (rd_load && r.cmd == `LSW_CMD_STATUS) begin
            n.below = 1'b0;
            n.above = 1'b0;
        end

        // (R17) shutdown drops new results
        if (meas_valid_i && !r.conf[`LSW_CONF_SD]) begin
            // (R09) result lands whole, high byte on top
            n.ambient = ambient_i;
            n.white   = white_i;
            // (R04) (R15) compare gated by enable
            if (!r.conf[`LSW_CONF_INT]) begin
                n.above_cnt = 4'h0;
                n.below_cnt = 4'h0;
            end else begin
                // (R12) above-window crossing
                if (ambient_i > r.upper) begin
                    if (r.above_cnt < pers_target) begin
                        n.above_cnt = r.above_cnt + 4'h1;
                    end
                    if (n.above_cnt >= pers_target) begin
                        n.above = 1'b1;
                    end
                end else begin
                    n.above_cnt = 4'h0;
                end
                // (R11) below-window crossing
                if (ambient_i < r.lower) begin
                    if (r.below_cnt < pers_target) begin
                        n.below_cnt = r.below_cnt + 4'h1;
                    end
                    if (n.below_cnt >= pers_target) begin
                        n.below = 1'b1;
                    end
                end else begin
                    n.below_cnt = 4'h0;
                end
            end
        end
    end

    always_ff @(posedge clk_i or posedge reset_i) begin
        if (reset_i) begin
            r <= RST;
        end else begin
            r <= n;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // outputs

    assign sda_o                 = r.sda_out;
    assign sda_oe_o              = r.sda_oe;
    assign conf_o                = r.conf;
    assign power_saving_on_o     = r.power_saving_control[`LSW_PSM_ON];
    assign power_saving_select_o = r.power_saving_control[`LSW_PSM_SEL_HI:`LSW_PSM_SEL_LO];
    assign below_window_flag_o   = r.below;
    assign above_window_flag_o   = r.above;

    ////////////////////////////////////////////////////////////////////////////
    // checks

    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (reset_i);

    AST_SD_HOLD: assert property ( // (R17)
        meas_valid_i && r.conf[`LSW_CONF_SD] |=> $stable(r.ambient) && $stable(r.white))
        else $error("result changed during shutdown");

    AST_RES_LOAD: assert property ( // (R08)
        meas_valid_i && !r.conf[`LSW_CONF_SD] |=> r.ambient == $past(ambient_i) && r.white == $past(white_i))
        else $error("result not captured");

    AST_IRQ_GATE: assert property ( // (R04)
        $rose(r.above) || $rose(r.below) |-> $past(r.conf[`LSW_CONF_INT]) && $past(meas_valid_i))
        else $error("flag set without enabled compare");

    AST_PERS_ONE: assert property ( // (R16)
        meas_valid_i && !r.conf[`LSW_CONF_SD] && r.conf[`LSW_CONF_INT] && pers_target == `LSW_PERS_ONE
        && ambient_i > r.upper |=> r.above)
        else $error("above flag missed at persistence one");

    AST_STATUS_CLR: assert property ( // (R18)
        rd_load && r.cmd == `LSW_CMD_STATUS && !meas_valid_i |=> !r.above && !r.below)
        else $error("status read did not clear flags");

    AST_WR_UPPER: assert property ( // (R01)
        wr_commit && r.cmd == `LSW_CMD_UPPER |=> r.upper == $past(wr_word))
        else $error("upper bound write lost");

    AST_WR_PSM: assert property ( // (R05)
        wr_commit && r.cmd == `LSW_CMD_PSM |=> {13'h0000, r.power_saving_control} == ($past(wr_word) & `LSW_PSM_MASK))
        else $error("power-saving write wrong");

    AST_ADDR_NACK: assert property ( // (R14)
        r.st == ST_ADDR && scl_fall && !start_det && !stop_det && r.bitcnt == `LSW_BITS_BYTE
        && r.shreg[7:1] != `LSW_DEV_ADDR |=> r.st == ST_WAIT && !r.sda_oe)
        else $error("foreign address acknowledged");

    AST_FIRST_BIT: assert property ( // (R19)
        r.st == ST_ACK && r.after == ST_RDATA && scl_fall && !start_det && !stop_det
        |=> r.st == ST_RDATA && r.sda_oe == !$past(r.tx[15]))
        else $error("first read bit wrong");

endmodule

`default_nettype wire

// >>> testbench/lsw_host_model.sv
// two-wire host model that frames word reads and writes
`timescale 1ns/1ps
`default_nettype none

module lsw_host_model #(
    parameter int HALF_NS = 32
) (
    // two-wire pins
    output logic      scl_o,
    output logic      sda_pull_o,
    input  wire logic sda_i
);
    localparam int Q = HALF_NS / 2;

    // clock stands high between frames
    initial begin
        scl_o = 1'b1;
        sda_pull_o = 1'b0;
    end

    // a full half period before the rise lets a late target release settle, so no false stop
    task automatic frame_start();
        sda_pull_o = 1'b0;
        #HALF_NS scl_o = 1'b1;
        #Q sda_pull_o = 1'b1;
        #Q scl_o = 1'b0;
        #Q;
    endtask

    task automatic frame_stop();
        sda_pull_o = 1'b1;
        #Q scl_o = 1'b1;
        #Q sda_pull_o = 1'b0;
        #HALF_NS;
    endtask

    // data changes mid low phase, away from both clock edges
    task automatic send_bit(input logic b);
        sda_pull_o = ~b;
        #Q scl_o = 1'b1;
        #HALF_NS scl_o = 1'b0;
        #Q;
    endtask

    // sampled at the end of the high phase, after the target's output delay
    task automatic take_bit(output logic b);
        sda_pull_o = 1'b0;
        #Q scl_o = 1'b1;
        #(HALF_NS - 1) b = sda_i;
        #1 scl_o = 1'b0;
        #Q;
    endtask

    task automatic put_byte(input logic [7:0] d, output logic ack);
        logic nack;
        for (int i = 7; i >= 0; i--)
            send_bit(d[i]);
        take_bit(nack);
        ack = ~nack;
    endtask

    task automatic get_byte(input logic last, output logic [7:0] d);
        for (int i = 7; i >= 0; i--)
            take_bit(d[i]);
        send_bit(last);
    endtask

    // address, command, low byte, high byte
    task automatic write_word(input logic [6:0] addr, input logic [7:0] cmd, input logic [15:0] data,
                              output logic ack);
        logic [3:0] a;
        frame_start();
        put_byte({addr, 1'b0}, a[0]);
        put_byte(cmd, a[1]);
        put_byte(data[7:0], a[2]);
        put_byte(data[15:8], a[3]);
        frame_stop();
        ack = &a;
    endtask

    task automatic read_word(input logic [6:0] addr, input logic [7:0] cmd, output logic [15:0] data,
                             output logic ack);
        logic [2:0] a;
        frame_start();
        put_byte({addr, 1'b0}, a[0]);
        put_byte(cmd, a[1]);
        frame_start();
        put_byte({addr, 1'b1}, a[2]);
        get_byte(1'b0, data[7:0]);
        get_byte(1'b1, data[15:8]);
        frame_stop();
        ack = &a;
    endtask
endmodule
`default_nettype wire

// >>> testbench/tb.sv
// self-checking bench for the light sensor window registers
`timescale 1ns/1ps
`default_nettype none
`include "lsw_defines.svh"

module tb;
    logic        clk_i = 1'b0;
    logic        reset_i;
    logic        scl;
    logic        sda_pull;
    logic        sda_wire;
    logic        sda_o;
    logic        sda_oe_o;
    logic        meas_valid_i;
    logic [15:0] ambient_i;
    logic [15:0] white_i;
    logic [15:0] conf_o;
    logic        power_saving_on_o;
    logic [1:0]  power_saving_select_o;
    logic        below_window_flag_o;
    logic        above_window_flag_o;
    int          miscompares = 0;
    int          checks_done = 0;
    // reference model state
    logic [15:0] m_conf, m_upper, m_lower, m_psm, m_amb, m_wht, rd;
    logic        m_below, m_above, ack;
    int          cnt_hi, cnt_lo;

    always #4 clk_i = ~clk_i;

    // open-drain data line with pull-up
    assign sda_wire = (sda_oe_o ? sda_o : 1'b1) & ~sda_pull;

    lsw_top dut_u (
        .clk_i(clk_i), .reset_i(reset_i), .scl_i(scl), .sda_i(sda_wire), .sda_o(sda_o),
        .sda_oe_o(sda_oe_o), .meas_valid_i(meas_valid_i), .ambient_i(ambient_i), .white_i(white_i),
        .conf_o(conf_o), .power_saving_on_o(power_saving_on_o), .power_saving_select_o(power_saving_select_o),
        .below_window_flag_o(below_window_flag_o), .above_window_flag_o(above_window_flag_o)
    );

    lsw_host_model #(.HALF_NS(32)) host_u (.scl_o(scl), .sda_pull_o(sda_pull), .sda_i(sda_wire));

    task automatic test_done();
        $display("comparisons %0d mismatches %0d", checks_done, miscompares);
        if (miscompares == 0 && checks_done > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask

    task automatic chk_word(input string name, input logic [15:0] exp, input logic [15:0] got);
        checks_done++;
        if (got !== exp) begin
            miscompares++;
            $display("CHECK FAILED %s expected %h seen %h", name, exp, got);
        end
    endtask

    task automatic chk_bit(input string name, input logic exp, input logic got);
        chk_word(name, {15'h0000, exp}, {15'h0000, got});
    endtask

    task automatic chk_outputs();
        chk_word("conf_o", m_conf, conf_o);
        chk_word("power saving", m_psm, {13'h0000, power_saving_select_o, power_saving_on_o});
        chk_bit("below flag", m_below, below_window_flag_o);
        chk_bit("above flag", m_above, above_window_flag_o);
    endtask

    task automatic reg_write(input logic [7:0] cmd, input logic [15:0] data);
        host_u.write_word(`LSW_DEV_ADDR, cmd, data, ack);
        chk_bit("write ack", 1'b1, ack);
        case (cmd)
            8'h00: m_conf = data;
            8'h01: m_upper = data;
            8'h02: m_lower = data;
            8'h03: m_psm = data & 16'h0007;
            default: ;
        endcase
        chk_outputs();
    endtask

    task automatic reg_read(input logic [7:0] cmd);
        logic [15:0] exp;
        case (cmd)
            8'h00: exp = m_conf;
            8'h01: exp = m_upper;
            8'h02: exp = m_lower;
            8'h03: exp = m_psm;
            8'h04: exp = m_amb;
            8'h05: exp = m_wht;
            8'h06: begin
                exp = {m_below, m_above, 14'h0000};
                m_below = 1'b0;
                m_above = 1'b0;
            end
            default: exp = 16'h0000;
        endcase
        host_u.read_word(`LSW_DEV_ADDR, cmd, rd, ack);
        chk_bit("read ack", 1'b1, ack);
        chk_word($sformatf("register %h", cmd), exp, rd);
        chk_outputs();
    endtask

    task automatic meas(input logic [15:0] a, input logic [15:0] w);
        int pers;
        @(posedge clk_i);
        #1;
        meas_valid_i = 1'b1;
        ambient_i = a;
        white_i = w;
        @(posedge clk_i);
        #1;
        meas_valid_i = 1'b0;
        pers = 1 << m_conf[5:4];
        // shutdown ignores the result entirely
        if (!m_conf[0]) begin
            m_amb = a;
            m_wht = w;
            cnt_hi = (m_conf[1] && a > m_upper) ? cnt_hi + 1 : 0;
            cnt_lo = (m_conf[1] && a < m_lower) ? cnt_lo + 1 : 0;
            if (cnt_hi >= pers)
                m_above = 1'b1;
            if (cnt_lo >= pers)
                m_below = 1'b1;
        end
        @(posedge clk_i);
        #1;
        chk_outputs();
    endtask

    initial begin
        reset_i = 1'b1;
        meas_valid_i = 1'b0;
        ambient_i = 16'h0000;
        white_i = 16'h0000;
        {m_upper, m_lower, m_psm, m_amb, m_wht} = '0;
        m_conf = 16'h0001;
        {m_below, m_above} = 2'b00;
        cnt_hi = 0;
        cnt_lo = 0;
        repeat (2) @(posedge clk_i);
        #1;
        reset_i = 1'b0;
        void'($urandom(9));
        repeat (4) @(posedge clk_i);
        #1;
        chk_outputs();
        for (int c = 0; c < 8; c++)
            reg_read(8'(c));
        for (int m = 0; m < 4; m++) begin
            reg_write(`LSW_CMD_PSM, (16'($urandom) & 16'hFFF8) | 16'(m << 1) | 16'($urandom_range(0, 1)));
            reg_read(`LSW_CMD_PSM);
        end
        reg_write(`LSW_CMD_UPPER, 16'($urandom));
        reg_read(`LSW_CMD_UPPER);
        reg_write(`LSW_CMD_LOWER, 16'($urandom));
        reg_read(`LSW_CMD_LOWER);
        // a third data byte is refused; the word of the first two stays
        host_u.frame_start();
        host_u.put_byte({`LSW_DEV_ADDR, 1'b0}, ack);
        host_u.put_byte(`LSW_CMD_UPPER, ack);
        host_u.put_byte(8'h34, ack);
        host_u.put_byte(8'h12, ack);
        chk_bit("second data ack", 1'b1, ack);
        host_u.put_byte(8'h56, ack);
        host_u.frame_stop();
        chk_bit("third data ack", 1'b0, ack);
        m_upper = 16'h1234;
        reg_read(`LSW_CMD_UPPER);
        reg_write(`LSW_CMD_UPPER, 16'h0800);
        reg_write(`LSW_CMD_LOWER, 16'h0100);
        reg_write(`LSW_CMD_AMBIENT, 16'hFFFF);
        reg_write(`LSW_CMD_STATUS, 16'hFFFF);
        reg_read(`LSW_CMD_AMBIENT);
        reg_read(`LSW_CMD_STATUS);
        host_u.write_word(7'h30, `LSW_CMD_UPPER, 16'hFFFF, ack);
        chk_bit("foreign address ack", 1'b0, ack);
        reg_read(`LSW_CMD_UPPER);
        // window function off: extreme results raise nothing
        reg_write(`LSW_CMD_CONF, 16'h0000);
        meas(16'hFFFF, 16'h1234);
        meas(16'h0000, 16'h4321);
        reg_write(`LSW_CMD_CONF, 16'h0002);
        for (int k = 0; k < 12; k++) begin
            meas(16'($urandom_range(0, 16'h0FFF)), 16'($urandom));
            if (k % 3 == 2)
                reg_read(`LSW_CMD_STATUS);
        end
        reg_read(`LSW_CMD_AMBIENT);
        reg_read(`LSW_CMD_WHITE);
        meas(16'h0400, 16'h0000);
        for (int p = 0; p < 4; p++) begin
            for (int d = 0; d < 2; d++) begin
                reg_write(`LSW_CMD_CONF, 16'(p << 4) | 16'h0002);
                for (int k = 0; k < (1 << p); k++)
                    meas(d ? 16'h0010 : 16'h0900, 16'($urandom));
                meas(16'h0400, 16'h0000);
                reg_read(`LSW_CMD_STATUS);
            end
        end
        reg_write(`LSW_CMD_CONF, 16'h0003);
        meas(16'hABCD, 16'h5555);
        reg_read(`LSW_CMD_AMBIENT);
        reg_read(`LSW_CMD_WHITE);
        reg_write(`LSW_CMD_CONF, 16'h0002);
        meas(16'hABCD, 16'h5555);
        reg_read(`LSW_CMD_AMBIENT);
        test_done();
    end

    // about 60 word transfers of 3 us each fit well inside this span
    initial begin
        #500000;
        miscompares++;
        test_done();
    end
endmodule
`default_nettype wire
